/* File: gopd_map.vh */
// Purpose: Format, size and mode codes, opcode codes and register numbers for the general-operation decoder
// Assumes: 32-bit instruction words, major opcode in bits 31:27
// Notes:   Definitions only
`ifndef GOPD_MAP_VH
`define GOPD_MAP_VH

`define GOPD_MAJOR_GENERAL  5'h04
`define GOPD_SUB_ADD        6'h00
`define GOPD_SUB_XOR        6'h07
`define GOPD_SUB_MAX        6'h08
`define GOPD_SUB_MIN        6'h09
`define GOPD_SUB_MOV        6'h0a
`define GOPD_SUB_CMP_LAST   6'h0d
`define GOPD_SUB_REVERSE_SUBTRACT_OP       6'h0e
`define GOPD_SUB_BSET       6'h0f
`define GOPD_SUB_BCLR       6'h10
`define GOPD_SUB_BTST       6'h11
`define GOPD_SUB_BXOR       6'h12
`define GOPD_SUB_BMSK       6'h13
`define GOPD_SUB_ADDS1      6'h14
`define GOPD_SUB_ADDS3      6'h16
`define GOPD_SUB_SUBS1      6'h17
`define GOPD_SUB_SUBS3      6'h19
`define GOPD_SUB_MUL_FIRST  6'h1a
`define GOPD_SUB_MUL_LAST   6'h1d
`define GOPD_SUB_JUMP       6'h20
`define GOPD_SUB_JUMP_LAST  6'h23
`define GOPD_SUB_LOOP       6'h28
`define GOPD_SUB_FLAG       6'h29
`define GOPD_SUB_AUX_READ   6'h2a
`define GOPD_SUB_AUX_WRITE  6'h2b
`define GOPD_SUB_SINGLE     6'h2f
`define GOPD_SUB_LOAD_FIRST 6'h30
`define GOPD_SUB_LOAD_LAST  6'h37
`define GOPD_SOP_LAST       6'h0c
`define GOPD_SOP_ZERO       6'h3f
`define GOPD_ZOP_FIRST      6'h01
`define GOPD_ZOP_LAST       6'h05

`define GOPD_REG_EXT_FIRST  6'h20
`define GOPD_REG_EXT_LAST   6'h3b
`define GOPD_REG_LOOP_CNT   6'h3c
`define GOPD_REG_PCV        6'h3d
`define GOPD_REG_LIMM       6'h3e
`define GOPD_REG_PC_HI      6'h3f
`define GOPD_REG_ILINK_A    6'h1d
`define GOPD_REG_ILINK_B    6'h1e

`define GOPD_FMT_RR         2'h0
`define GOPD_FMT_U6         2'h1
`define GOPD_FMT_S12        2'h2
`define GOPD_FMT_COND       2'h3
`define GOPD_SIZE_LONG      2'h0
`define GOPD_SIZE_BAD       2'h3
`define GOPD_AM_PRE         2'h1
`define GOPD_AM_POST        2'h2

// Operation select codes on alu_op_out
`define GOPD_OP_WIDTH       6
`define GOPD_OP_NONE        6'h3f
`define GOPD_OP_SOP_BASE    6'h20

// Exception cause codes
`define GOPD_EXC_NONE       2'h0
`define GOPD_EXC_INSTR      2'h1
`define GOPD_EXC_PRIV       2'h2

`endif

/* File: gopd_decoder.v */
// Purpose: Decoder and operation selector for the 32-bit general-operations major opcode
// Assumes: One instruction word per cycle from fetch; results registered one cycle later
// Notes:   Single-operand ops appear as op codes offset by the single-source base
//
// Operation
// - Sub-ops 0x00-0x07 select add, add-carry, sub, sub-borrow, and, or, and-inverted, xor.
// - 0x08 selects signed maximum, 0x09 signed minimum.
// - 0x14-0x16 add second source shifted left by one, two, three.
// - 0x17-0x19 subtract second source shifted left by one, two, three.
// - 0x1A-0x1D signed low, signed high, unsigned high, unsigned low product word.
// - Move, test, compares and bit test ignore A; B is destination or first operand.
// - Reserved sub-ops 0x1E,0x1F,0x24-0x27,0x2C-0x2E,0x38-0x3F raise instruction error.
// - 0x20-0x23 jump to C; odd codes have delay slot; 0x22/0x23 save link.
// - Jumps ignore B, and ignore A in formats 0 and 1.
// - Jump flag bit must be set exactly when target is an interrupt link register.
// - 0x28 sets loop end to pc plus C and loop start to next pc.
// - 0x29 writes status, 0x2A reads aux C into B, 0x2B writes B to aux C.
// - Loads 0x30-0x37 decode bypass bit 15, mode 23:22, size 18:17, sign 16.
// - Load destination 0x20-0x3B, 0x3D or 0x3F raises instruction error.
// - Load destination 0x3C raises privilege violation instead of writing.
// - Load data size 0x3 raises instruction error.
// - Load sign extension with longword size raises instruction error.
// - Load write-back modes 1 or 2 with long-immediate base raise instruction error.
// - Load to long-immediate destination is a prefetch when supported, else an error.
// - Sub-op 0x2F reinterprets A as a single-source sub-op from C into B.
// - Single-source codes 0x00-0x0C map to their ops; 0x0D-0x3E raise instruction error.
// - Zero-operand B codes 0x01-0x05 map; 0x00 and 0x06 upward raise instruction error.
// - Format 00 registers, 01 unsigned 6-bit, 10 signed 12-bit, 11 conditional.
// - Long-immediate source takes next word; long-immediate destination discards result.
//
`timescale 1ns/1ps
`include "gopd_map.vh"

module gopd_decoder #(
    parameter PREFETCH_OK = 1
) (
    // Clock and reset
    input  wire        clk_in,
    input  wire        rst_n_in,
    // Instruction from fetch
    input  wire        instr_valid_in,
    input  wire [31:0] instr_in,
    // Operand selection
    output reg  [5:0]  src1_reg_out,
    output reg  [5:0]  src2_reg_out,
    output reg  [5:0]  dest_reg_out,
    output reg         src1_limm_out,
    output reg         src2_limm_out,
    output reg         src2_is_imm_out,
    output reg  [31:0] src2_imm_out,
    output reg         cond_out,
    output reg  [4:0]  cond_code_out,
    output reg         set_flags_out,
    // Execute controls
    output reg         valid_out,
    output reg  [5:0]  alu_op_out,
    output reg  [1:0]  shift_amt_out,
    output reg         reg_write_out,
    // Flow control
    output reg         jump_out,
    output reg         delay_slot_out,
    output reg         link_out,
    output reg         loop_setup_out,
    // Auxiliary register access
    output reg         aux_read_out,
    output reg         aux_write_out,
    output reg         status_write_out,
    // Load controls
    output reg         load_out,
    output reg         prefetch_out,
    output reg         cache_bypass_bit_out,
    output reg  [1:0]  addr_mode_out,
    output reg  [1:0]  data_size_field_out,
    output reg         sign_ext_out,
    // Zero-operand and atomic exchange controls
    output reg         sleep_out,
    output reg         software_interrupt_op_out,
    output reg         sync_out,
    output reg         exception_return_op_out,
    output reg         breakpoint_op_out,
    output reg         atomic_swap_op_out,
    // Exceptions
    output reg  [1:0]  exc_cause_out
);

    // Instruction fields
    wire [4:0] major_w = instr_in[31:27];
    wire [1:0] fmt_w   = instr_in[23:22];
    wire [5:0] sub_w   = instr_in[21:16];
    wire       f_w     = instr_in[15];
    wire [5:0] b_w     = {instr_in[14:12], instr_in[26:24]};
    wire [5:0] c_w     = instr_in[11:6];
    wire [5:0] a_w     = instr_in[5:0];
    wire       m_w     = instr_in[5];
    // Words of other major opcodes are left to other decoders
    wire       dec_ok  = instr_valid_in && (major_w == `GOPD_MAJOR_GENERAL);

    // Combinational decode results
    reg [5:0]  src1_nxt;
    reg [5:0]  src2_nxt;
    reg [5:0]  dest_nxt;
    reg        s2imm_nxt;
    reg [31:0] imm_nxt;
    reg        cond_nxt;
    reg [5:0]  op_nxt;
    reg [1:0]  shamt_nxt;
    reg        wr_nxt;
    reg        jump_nxt;
    reg        dslot_nxt;
    reg        link_nxt;
    reg        loop_nxt;
    reg        auxr_nxt;
    reg        auxw_nxt;
    reg        stat_nxt;
    reg        load_nxt;
    reg        pref_nxt;
    reg [4:0]  zop_nxt;
    reg        xchg_nxt;
    reg        ierr_nxt;
    reg        priv_nxt;
    reg        is_load;

    always @* begin
        src1_nxt  = b_w;
        src2_nxt  = c_w;
        dest_nxt  = a_w;
        s2imm_nxt = 1'b0;
        imm_nxt   = 32'h0000_0000;
        cond_nxt  = 1'b0;
        op_nxt    = sub_w;
        shamt_nxt = 2'h0;
        wr_nxt    = 1'b0;
        jump_nxt  = 1'b0;
        dslot_nxt = 1'b0;
        link_nxt  = 1'b0;
        loop_nxt  = 1'b0;
        auxr_nxt  = 1'b0;
        auxw_nxt  = 1'b0;
        stat_nxt  = 1'b0;
        load_nxt  = 1'b0;
        pref_nxt  = 1'b0;
        zop_nxt   = 5'h00;
        xchg_nxt  = 1'b0;
        ierr_nxt  = 1'b0;
        priv_nxt  = 1'b0;
        is_load   = (sub_w >= `GOPD_SUB_LOAD_FIRST) && (sub_w <= `GOPD_SUB_LOAD_LAST);
        // Loads reuse the format bits as addressing mode, so no operand format applies
        if (!is_load) begin
            case (fmt_w)
                `GOPD_FMT_RR: begin
                    s2imm_nxt = 1'b0;
                end
                `GOPD_FMT_U6: begin
                    s2imm_nxt = 1'b1;
                    imm_nxt   = {26'h0, c_w};
                end
                `GOPD_FMT_S12: begin
                    s2imm_nxt = 1'b1;
                    imm_nxt   = {{20{a_w[5]}}, a_w, c_w};
                    dest_nxt  = b_w;
                end
                default: begin
                    cond_nxt  = 1'b1;
                    s2imm_nxt = m_w;
                    imm_nxt   = {26'h0, c_w};
                    dest_nxt  = b_w;
                end
            endcase
        end
        if (sub_w <= `GOPD_SUB_MUL_LAST) begin
            wr_nxt = 1'b1;
            if (sub_w >= `GOPD_SUB_ADDS1 && sub_w <= `GOPD_SUB_ADDS3)
                shamt_nxt = sub_w[1:0] - 2'h3;
            if (sub_w >= `GOPD_SUB_SUBS1 && sub_w <= `GOPD_SUB_SUBS3)
                shamt_nxt = sub_w[1:0] + 2'h2;
            // Max, min and products keep their sub-op as the op code
            if (sub_w >= `GOPD_SUB_MOV && sub_w <= `GOPD_SUB_CMP_LAST || sub_w == `GOPD_SUB_BTST) begin
                dest_nxt = b_w;
                wr_nxt   = (sub_w == `GOPD_SUB_MOV);
            end
        end else begin
            case (sub_w)
                `GOPD_SUB_JUMP, 6'h21, 6'h22, 6'h23: begin
                    // B ignored always, A ignored in formats 0 and 1
                    jump_nxt  = 1'b1;
                    dslot_nxt = sub_w[0];
                    link_nxt  = sub_w[1];
                    src1_nxt  = 6'h00;
                    dest_nxt  = 6'h00;
                    if (!s2imm_nxt && (c_w == `GOPD_REG_ILINK_A || c_w == `GOPD_REG_ILINK_B))
                        ierr_nxt = !f_w;
                    else
                        ierr_nxt = f_w;
                end
                `GOPD_SUB_LOOP: begin
                    loop_nxt = 1'b1;
                end
                `GOPD_SUB_FLAG: begin
                    stat_nxt = 1'b1;
                end
                `GOPD_SUB_AUX_READ: begin
                    auxr_nxt = 1'b1;
                    wr_nxt   = 1'b1;
                    dest_nxt = b_w;
                end
                `GOPD_SUB_AUX_WRITE: begin
                    auxw_nxt = 1'b1;
                end
                `GOPD_SUB_SINGLE: begin
                    // The A field is a second sub-op; result goes to B
                    dest_nxt = b_w;
                    src1_nxt = c_w;
                    if (fmt_w == `GOPD_FMT_S12 || fmt_w == `GOPD_FMT_COND) begin
                        ierr_nxt = 1'b1;
                    end else if (a_w <= `GOPD_SOP_LAST) begin
                        // OR instead of add: codes stay below the base, so no carry can be lost
                        op_nxt   = `GOPD_OP_SOP_BASE | a_w;
                        wr_nxt   = 1'b1;
                        xchg_nxt = (a_w == `GOPD_SOP_LAST);
                    end else if (a_w == `GOPD_SOP_ZERO) begin
                        op_nxt   = `GOPD_OP_NONE;
                        dest_nxt = 6'h00;
                        if (b_w >= `GOPD_ZOP_FIRST && b_w <= `GOPD_ZOP_LAST)
                            zop_nxt = 5'h01 << (b_w[2:0] - 3'h1);
                        else
                            ierr_nxt = 1'b1;
                    end else begin
                        ierr_nxt = 1'b1;
                    end
                end
                6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37: begin
                    load_nxt = 1'b1;
                    wr_nxt   = 1'b1;
                    op_nxt   = `GOPD_OP_NONE;
                    if (instr_in[18:17] == `GOPD_SIZE_BAD)
                        ierr_nxt = 1'b1;
                    if (instr_in[16] && instr_in[18:17] == `GOPD_SIZE_LONG)
                        ierr_nxt = 1'b1;
                    if ((fmt_w == `GOPD_AM_PRE || fmt_w == `GOPD_AM_POST) && b_w == `GOPD_REG_LIMM)
                        ierr_nxt = 1'b1;
                    if (a_w >= `GOPD_REG_EXT_FIRST && a_w <= `GOPD_REG_EXT_LAST)
                        ierr_nxt = 1'b1;
                    if (a_w == `GOPD_REG_PCV || a_w == `GOPD_REG_PC_HI)
                        ierr_nxt = 1'b1;
                    if (a_w == `GOPD_REG_LIMM) begin
                        // Prefetch only where the implementation supports it
                        pref_nxt = (PREFETCH_OK != 0);
                        ierr_nxt = ierr_nxt | (PREFETCH_OK == 0);
                        wr_nxt   = 1'b0;
                    end
                    if (a_w == `GOPD_REG_LOOP_CNT)
                        priv_nxt = 1'b1;
                end
                default: begin
                    ierr_nxt = 1'b1;
                end
            endcase
        end
        // Discard result to the long-immediate slot but keep flag updates
        if (dest_nxt == `GOPD_REG_LIMM)
            wr_nxt = 1'b0;
        // Instruction error outranks privilege so only one cause leaves
        if (ierr_nxt || priv_nxt) begin
            wr_nxt   = 1'b0;
            auxw_nxt = 1'b0;
            stat_nxt = 1'b0;
            loop_nxt = 1'b0;
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            src1_reg_out              <= 6'h00;
            src2_reg_out              <= 6'h00;
            dest_reg_out              <= 6'h00;
            src1_limm_out             <= 1'b0;
            src2_limm_out             <= 1'b0;
            src2_is_imm_out           <= 1'b0;
            src2_imm_out              <= 32'h0000_0000;
            cond_out                  <= 1'b0;
            cond_code_out             <= 5'h00;
            set_flags_out             <= 1'b0;
            valid_out                 <= 1'b0;
            alu_op_out                <= `GOPD_OP_NONE;
            shift_amt_out             <= 2'h0;
            reg_write_out             <= 1'b0;
            jump_out                  <= 1'b0;
            delay_slot_out            <= 1'b0;
            link_out                  <= 1'b0;
            loop_setup_out            <= 1'b0;
            aux_read_out              <= 1'b0;
            aux_write_out             <= 1'b0;
            status_write_out          <= 1'b0;
            load_out                  <= 1'b0;
            prefetch_out              <= 1'b0;
            cache_bypass_bit_out      <= 1'b0;
            addr_mode_out             <= 2'h0;
            data_size_field_out       <= 2'h0;
            sign_ext_out              <= 1'b0;
            sleep_out                 <= 1'b0;
            software_interrupt_op_out <= 1'b0;
            sync_out                  <= 1'b0;
            exception_return_op_out   <= 1'b0;
            breakpoint_op_out         <= 1'b0;
            atomic_swap_op_out        <= 1'b0;
            exc_cause_out             <= `GOPD_EXC_NONE;
        end else begin
            // Enables and the exception cause are gated by a decoded word; op code, operand fields, cond and load fields follow any word
            valid_out                 <= dec_ok;
            src1_reg_out              <= src1_nxt;
            src2_reg_out              <= src2_nxt;
            dest_reg_out              <= dest_nxt;
            src1_limm_out             <= dec_ok && src1_nxt == `GOPD_REG_LIMM;
            src2_limm_out             <= dec_ok && !s2imm_nxt && src2_nxt == `GOPD_REG_LIMM;
            src2_is_imm_out           <= s2imm_nxt;
            src2_imm_out              <= imm_nxt;
            cond_out                  <= cond_nxt;
            cond_code_out             <= instr_in[4:0];
            set_flags_out             <= dec_ok && !is_load && f_w && !jump_nxt;
            alu_op_out                <= op_nxt;
            shift_amt_out             <= shamt_nxt;
            reg_write_out             <= dec_ok && wr_nxt;
            jump_out                  <= dec_ok && jump_nxt && !ierr_nxt;
            delay_slot_out            <= dec_ok && dslot_nxt && !ierr_nxt;
            link_out                  <= dec_ok && link_nxt && !ierr_nxt;
            loop_setup_out            <= dec_ok && loop_nxt;
            aux_read_out              <= dec_ok && auxr_nxt && !ierr_nxt;
            aux_write_out             <= dec_ok && auxw_nxt;
            status_write_out          <= dec_ok && stat_nxt;
            load_out                  <= dec_ok && load_nxt && !ierr_nxt && !priv_nxt;
            prefetch_out              <= dec_ok && pref_nxt && !ierr_nxt && !priv_nxt;
            cache_bypass_bit_out      <= is_load & f_w;
            addr_mode_out             <= is_load ? fmt_w : 2'h0;
            data_size_field_out       <= instr_in[18:17];
            sign_ext_out              <= is_load & instr_in[16];
            sleep_out                 <= dec_ok && zop_nxt[0];
            software_interrupt_op_out <= dec_ok && zop_nxt[1];
            sync_out                  <= dec_ok && zop_nxt[2];
            exception_return_op_out   <= dec_ok && zop_nxt[3];
            breakpoint_op_out         <= dec_ok && zop_nxt[4];
            atomic_swap_op_out        <= dec_ok && xchg_nxt && !ierr_nxt;
            exc_cause_out             <= !dec_ok ? `GOPD_EXC_NONE :
                                         ierr_nxt ? `GOPD_EXC_INSTR :
                                         priv_nxt ? `GOPD_EXC_PRIV : `GOPD_EXC_NONE;
        end
    end

endmodule // gopd_decoder

/* File: gopd_fetch_model.sv */
// Purpose: Fetch-stage model that hands instruction words to the decoder
// Assumes: One word per send; Notes: an idle bus shows the inverted last word
`timescale 1ns/1ps
module gopd_fetch_model (
    // Clock
    input  wire         clk_in,
    // Toward the decoder
    output logic        valid_out,
    output logic [31:0] word_out
);
    initial {valid_out, word_out} = 33'h0;
    // Word stands for its taking edge only, then goes stale so no old value can pass
    task automatic send(input logic [31:0] word);
        @(posedge clk_in);
        valid_out <= 1'b1;
        word_out  <= word;
        @(posedge clk_in);
        valid_out <= 1'b0;
        word_out  <= ~word;
    endtask
endmodule // gopd_fetch_model

/* File: gopd_decoder_props.sv */
// Purpose: Port checks for the general-operation decoder
// Assumes: One-cycle registered answer; Notes: bound to every decoder instance
`timescale 1ns/1ps
module gopd_decoder_props (
    // Clock and reset
    input wire        clk_in,
    input wire        rst_n_in,
    // Instruction
    input wire        instr_valid_in,
    input wire [31:0] instr_in,
    // Decoded controls
    input wire [5:0]  alu_op_out,
    input wire [1:0]  shift_amt_out,
    input wire        reg_write_out,
    input wire        jump_out,
    input wire        delay_slot_out,
    input wire        link_out,
    input wire        aux_write_out,
    input wire        status_write_out,
    input wire [1:0]  exc_cause_out
);
    wire       tk  = instr_valid_in && instr_in[31:27] == 5'h04;
    wire       rr  = instr_in[23:22] == 2'h0;
    wire [5:0] sub = instr_in[21:16];
    wire [5:0] fa  = instr_in[5:0];
    wire [5:0] fc  = instr_in[11:6];
    wire       il  = fc == 6'h1d || fc == 6'h1e;
    wire       jp  = tk && rr && sub[5:2] == 4'h8;
    wire       ld  = tk && sub[5:3] == 3'h6;
    wire       lde = sub[2:1] == 2'h3 || sub[2:0] == 3'h1 || (fa >= 6'h20 && fa != 6'h3c && fa != 6'h3e)
                     || (instr_in[23] != instr_in[22] && {instr_in[14:12], instr_in[26:24]} == 6'h3e);
    wire [1:0] sh  = sub[1:0] - (sub <= 6'h16 ? 2'h3 : 2'h2);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_jump_ok;
        jp && il == instr_in[15];
    endsequence
    alu_op_sel_a:
        assert property (tk && rr && sub <= 6'h1d |=> alu_op_out == $past(sub)) else $error("alu op wrong");
    shift_amount_a:
        assert property (tk && sub >= 6'h14 && sub <= 6'h19 |=> shift_amt_out == $past(sh)) else $error("shift wrong");
    reserved_op_a:
        assert property (tk && sub inside {[6'h1e:6'h1f], [6'h24:6'h27], [6'h2c:6'h2e], [6'h38:6'h3f]}
            |=> exc_cause_out == 2'h1) else $error("reserved op taken");
    jump_ctrl_a:
        assert property (s_jump_ok |=> jump_out && delay_slot_out == $past(instr_in[16])
            && link_out == $past(instr_in[17])) else $error("jump controls wrong");
    jump_flag_a:
        assert property (jp && il != instr_in[15] |=> exc_cause_out == 2'h1 && !jump_out) else $error("jump flag taken");
    load_error_a:
        assert property (ld && lde |=> exc_cause_out == 2'h1 && !reg_write_out) else $error("bad load taken");
    load_priv_a:
        assert property (ld && !lde && fa == 6'h3c |=> exc_cause_out == 2'h2 && !reg_write_out) else $error("no priv");
    no_write_a:
        assert property (exc_cause_out != 2'h0 |-> !reg_write_out && !aux_write_out && !status_write_out)
            else $error("write on exception");
endmodule // gopd_decoder_props
bind gopd_decoder gopd_decoder_props u_props (.*);

/* File: general_op_decoder_test.sv */
// Purpose: Self-checking bench for the general-operation decoder
// Assumes: One-cycle answer; Notes: words enter through the fetch model
`timescale 1ns/1ps
module general_op_decoder_test;
    logic       clk_in = 1'b0;
    logic       rst_n_in = 1'b0;
    int         checks = 0;
    int         miscompares = 0;
    wire [31:0] instr_in, src2_imm_out;
    wire [5:0]  src1_reg_out, src2_reg_out, dest_reg_out, alu_op_out;
    wire [4:0]  cond_code_out;
    wire [1:0]  shift_amt_out, addr_mode_out, data_size_field_out, exc_cause_out;
    wire        instr_valid_in, src1_limm_out, src2_limm_out, src2_is_imm_out, cond_out, set_flags_out, valid_out;
    wire        reg_write_out, jump_out, delay_slot_out, link_out, loop_setup_out, aux_read_out, aux_write_out;
    wire        status_write_out, load_out, prefetch_out, cache_bypass_bit_out, sign_ext_out, sleep_out, sync_out;
    wire        software_interrupt_op_out, exception_return_op_out, breakpoint_op_out, atomic_swap_op_out;
    wire [4:0]  zero_ops = {breakpoint_op_out, exception_return_op_out, sync_out, software_interrupt_op_out, sleep_out};
    gopd_fetch_model u_fetch (.clk_in(clk_in), .valid_out(instr_valid_in), .word_out(instr_in));
    gopd_decoder #(.PREFETCH_OK(1)) DUT (.*);
    always #5 clk_in = ~clk_in;
    function automatic logic [31:0] w(input logic [1:0] p, input logic [5:0] i, b, c, a, input logic f);
        return {5'h04, b[2:0], p, i, f, b[5:3], c, a};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Outputs stand one cycle only, so they are read just after the taking edge
    task automatic run(input logic [31:0] word);
        u_fetch.send(word);
        #1;
    endtask
    task automatic t_ops;
        logic e;
        for (int i = 0; i < 'h40; i++) begin
            e = i inside {['h1e:'h1f], ['h24:'h27], ['h2c:'h2e], ['h38:'h3f], 'h31, 'h36, 'h37};
            run(w(2'h0, i[5:0], 6'h07, 6'h09, 6'h05, 1'b0));
            chk(exc_cause_out, e);
            if (e) chk(reg_write_out, 0);
            if (i <= 'h1d) chk(alu_op_out, i);
            if (i >= 'h14 && i <= 'h19) chk(shift_amt_out, (i - 'h14) % 3 + 1);
            if (i inside {['h0a:'h0d], 'h11}) chk(dest_reg_out, 'h07);
        end
        $display("test ops done");
    endtask
    task automatic t_flow;
        for (int k = 0; k < 4; k++) begin
            run(w(2'h1, 6'h20 + k[5:0], 6'h15, 6'h08, 6'h2a, 1'b0));
            chk({jump_out, delay_slot_out, link_out, exc_cause_out}, {1'b1, k[0], k[1], 2'h0});
            run(w(2'h0, 6'h20, 6'h00, k == 3 ? 6'h05 : 6'h1d + {5'h0, k[0]}, 6'h00, k != 2));
            chk(exc_cause_out, k >= 2);
            run(w(2'h0, 6'h28 + k[5:0], 6'h03, 6'h04, 6'h05, 1'b0));
            chk({loop_setup_out, status_write_out, aux_read_out, aux_write_out}, 4'h8 >> k);
        end
        $display("test flow done");
    endtask
    task automatic t_load;
        logic [1:0] zz;
        int dst[7] = '{'h20, 'h3b, 'h3d, 'h3f, 'h3c, 'h02, 'h02};
        for (int k = 0; k < 12; k++) begin
            zz = 2'(k / 4);
            run(w(k[1:0], {3'h6, zz, zz != 2'h0 && k[0]}, 6'h04, 6'h06, 6'h02, k[2]));
            chk({load_out, cache_bypass_bit_out, addr_mode_out, exc_cause_out}, {1'b1, k[2], k[1:0], 2'h0});
            chk({data_size_field_out, sign_ext_out}, {zz, zz != 2'h0 && k[0]});
        end
        for (int j = 0; j < 7; j++) begin
            run(w(j > 4 ? 2'(j - 4) : 2'h0, 6'h32, j > 4 ? 6'h3e : 6'h04, 6'h06, 6'(dst[j]), 1'b0));
            chk({reg_write_out, exc_cause_out}, j == 4 ? 3'h2 : 3'h1);
        end
        run(w(2'h0, 6'h32, 6'h04, 6'h06, 6'h3e, 1'b0));
        chk({prefetch_out, reg_write_out, exc_cause_out}, 4'h8);
        $display("test load done");
    endtask
    task automatic t_single;
        int ok;
        for (int a = 0; a < 'h40; a++) begin
            run(w(2'h0, 6'h2f, 6'h07, 6'h09, a[5:0], 1'b0));
            chk(exc_cause_out, a > 'h0c);
            if (a <= 'h0c) chk(alu_op_out, 'h20 + a);
            chk(atomic_swap_op_out, a == 'h0c);
        end
        for (int b = 0; b < 8; b++) begin
            ok = b inside {[1:5]};
            run(w(2'h1, 6'h2f, b[5:0], 6'h00, 6'h3f, 1'b0));
            chk(zero_ops, (ok << b) >> 1);
            chk(exc_cause_out, !ok);
        end
        $display("test single done");
    endtask
    task automatic t_format;
        run(w(2'h2, 6'h00, 6'h03, 6'h05, 6'h3c, 1'b0));
        chk(src2_imm_out, 'hffffff05);
        run(w(2'h3, 6'h00, 6'h03, 6'h11, 6'h23, 1'b0));
        chk({cond_out, cond_code_out, src2_is_imm_out, src2_imm_out[5:0]}, 13'h11d1);
        run(w(2'h0, 6'h00, 6'h3e, 6'h04, 6'h3e, 1'b1));
        chk({src1_limm_out, reg_write_out, set_flags_out}, 3'h5);
        run({5'h05, 27'h0});
        chk({valid_out, reg_write_out}, 2'h0);
        @(posedge clk_in) rst_n_in <= 1'b0;
        #1 chk({alu_op_out, valid_out, exc_cause_out}, 9'h1f8);
        @(posedge clk_in) rst_n_in <= 1'b1;
        run(w(2'h0, 6'h00, 6'h03, 6'h3e, 6'h05, 1'b0));
        chk({valid_out, src1_reg_out, src2_reg_out, src2_limm_out, dest_reg_out}, {7'h43, 6'h3e, 7'h45});
        $display("test format done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_ops();
        t_flow();
        t_load();
        t_single();
        t_format();
        report_and_stop();
    end
    // Cuts a hang short
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
endmodule // general_op_decoder_test
